// *** verilog/powerdown_entry_exit_control.sv ***
// power-down entry and exit sequencer with timing-pin wake delay
`timescale 1ns/1ns
`include "pwr_seq_map.svh"

// Notes on behaviour
// - power-down starts only when the request bit is one and a halt executes.
// - in power-down, only the interrupt or the reset input ends the mode.
// - interrupt wake keeps clocks off until the capacitor delay elapses.
// - reset wake skips the capacitor delay; reset alone restarts.
// - an interrupt assertion is latched so a short pulse is kept.
// - reset input low aborts bus cycles, initialises, and drives reset out.
module powerdown_entry_exit_control #(
    parameter int DISCHARGE_CYC = `PWR_DISCHARGE_CYC
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_resin_n,
    input  wire logic                     i_nmi,
    input  wire logic                     i_power_down_request_bit,
    input  wire logic                     i_halt_exec,
    input  wire logic                     i_nmi_taken,
    input  wire logic                     i_pdtmr_in,
    output logic                          o_pdtmr_out,
    output logic                          o_pdtmr_oe,
    output logic                          o_clk_en,
    output logic                          o_resout,
    output logic                          o_bus_abort,
    output pwr_seq_pkg::pwr_status_t      o_status
);
    import pwr_seq_pkg::*;

    // sequence overview
    //   run      : clocks on; a halt with the request bit set parks the core
    //   down     : clocks off, timing pin held low to empty the capacitor;
    //              the discharge counter must expire before an interrupt wake can start
    //   wake_nmi : pin released, the capacitor charges through the board;
    //              clocks return once the synchronised pin reads high
    //   reset    : entered from any state while the reset pin is low; clocks
    //              run at once so the reset path never waits on the capacitor
    // limitation: an interrupt that arrives during discharge is held in the
    // latch and starts the wake only when the counter has expired, so the
    // worst-case wake time is the discharge time plus the capacitor delay
    // trade-off: every pin passes two flops, which adds two cycles to each
    // reaction but keeps metastability away from the state register

    localparam int CW = $clog2(DISCHARGE_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // state decoding helpers

    // clocks run in normal operation and through reset
    function automatic logic clocks_on(input pwr_state_t s);
        clocks_on = (s == ST_RUN) || (s == ST_RESET);
    endfunction

    // parked covers the discharge phase and the interrupt wake delay
    function automatic logic parked(input pwr_state_t s);
        parked = (s == ST_DOWN) || (s == ST_WAKE_NMI);
    endfunction

    // the timing pin is pulled low only while waiting for a wake event
    function automatic logic discharging(input pwr_state_t s);
        discharging = (s == ST_DOWN);
    endfunction

    // a wake starts only from an empty capacitor, otherwise the delay shrinks
    function automatic logic wake_ready(input logic pending, input logic empty);
        wake_ready = pending && empty;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // synchronised pins

    // synchronised pin levels, named for the logic that reads them
    logic       resin_n_s;
    logic       nmi_s;
    logic       pdtmr_s;
    logic [2:0] pins_s;

    // reset pin starts asserted so nothing runs before it is seen high
    pin_sync #(
        .WIDTH (3),
        .INIT  (3'h0)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_resin_n, i_nmi, i_pdtmr_in}),
        .o_sync  (pins_s)
    );

    assign resin_n_s = pins_s[2];
    assign nmi_s     = pins_s[1];
    assign pdtmr_s   = pins_s[0];

    ////////////////////////////////////////////////////////////////////////////
    // state and registers

    // sequencer state, latch, discharge count and the next values of outputs
    pwr_state_t state_q;
    pwr_state_t state_d;
    logic       nmi_seen_q;
    logic       nmi_q;
    logic       clk_en_d;
    logic       pd_oe_d;
    logic       down_d;
    logic       pending_d;
    pwr_status_t status_d;
    logic [CW-1:0] dis_cnt_q;

    // events seen by the state machine
    wire reset_req  = ~resin_n_s;
    wire nmi_rise   = nmi_s & ~nmi_q;
    wire enter_down = i_power_down_request_bit & i_halt_exec;
    wire discharged = (dis_cnt_q == CW'(DISCHARGE_CYC));
    wire wake_nmi   = nmi_rise | nmi_seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // state machine

    // next state: reset outranks everything, the pin threshold ends the wake
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                // either condition alone leaves the core running
                if (reset_req)       state_d = ST_RESET;
                else if (enter_down) state_d = ST_DOWN;
            end
            ST_DOWN: begin
                // only the interrupt or the reset pin may end the mode
                if (reset_req)       state_d = ST_RESET;
                else if (wake_ready(wake_nmi, discharged)) state_d = ST_WAKE_NMI;
            end
            ST_WAKE_NMI: begin
                // the pin threshold is the only way back to run from here
                if (reset_req)       state_d = ST_RESET;
                else if (pdtmr_s)    state_d = ST_RUN;
            end
            ST_RESET: begin
                // reset restarts directly, no capacitor delay
                if (!reset_req)      state_d = ST_RUN;
            end
            default: state_d = ST_RESET;
        endcase
    end

    // clocks run only in run and reset; timing pin driven low only while down
    assign clk_en_d  = clocks_on(state_d);
    assign pd_oe_d   = discharging(state_d);
    assign down_d    = parked(state_d);

    // status word gathered on named wires so the output flop stays simple
    assign pending_d = nmi_seen_q | nmi_rise;
    assign status_d  = '{clk_en: clk_en_d, powered_down: down_d, nmi_pending: pending_d};

    // state register; reset parks in the reset state until the pin reads high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // previous interrupt level for the edge detector; resets low to match the
    // idle level of the pin so no false edge follows reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= nmi_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt latch and discharge timer

    // the latch holds a short pulse; a new edge wins over the clear
    always_ff @(posedge i_clk) begin
        if (i_rst || reset_req) begin
            nmi_seen_q <= 1'b0;
        end else if (nmi_rise) begin
            nmi_seen_q <= 1'b1;
        end else if (i_nmi_taken) begin
            nmi_seen_q <= 1'b0;
        end
    end

    // discharge time so a partly charged cap cannot shorten the wake delay
    always_ff @(posedge i_clk) begin
        if (i_rst || state_q != ST_DOWN) begin
            dis_cnt_q <= '0;
        end else if (!discharged) begin
            dis_cnt_q <= dis_cnt_q + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_clk_en    <= `PWR_CLK_EN_RESET;
            o_resout    <= `PWR_RESOUT_RESET;
            o_bus_abort <= 1'b1;
            o_pdtmr_out <= 1'b0;
            o_pdtmr_oe  <= 1'b0;
            o_status    <= '0;
        end else begin
            o_clk_en    <= clk_en_d;
            o_resout    <= reset_req;
            o_bus_abort <= reset_req;
            // the pin is only ever pulled low; release is by dropping the enable
            o_pdtmr_out <= 1'b0;
            o_pdtmr_oe  <= pd_oe_d;
            o_status    <= status_d;
        end
    end
endmodule

// *** verilog/pwr_seq_map.svh ***
// timing and reset constants of the power-down sequencer
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH
`define PWR_CLK_PERIOD_NS    8
`define PWR_DISCHARGE_NS     800
`define PWR_DISCHARGE_CYC    ((`PWR_DISCHARGE_NS + `PWR_CLK_PERIOD_NS - 1) / `PWR_CLK_PERIOD_NS)
`define PWR_REQ_RESET        1'b0
`define PWR_CLK_EN_RESET     1'b1
`define PWR_RESOUT_RESET     1'b1
`endif

// *** verilog/pwr_seq_pkg.sv ***
// types of the power-down sequencer
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_DOWN,
        ST_WAKE_NMI,
        ST_RESET
    } pwr_state_t;

    typedef struct packed {
        logic clk_en;
        logic powered_down;
        logic nmi_pending;
    } pwr_status_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;
endpackage

// *** verilog/pin_sync.sv ***
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= INIT;
            o_sync <= INIT;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// *** tb/pwr_seq_chk.sv ***
// port assertions for the power-down sequencer
`timescale 1ns/1ns
module pwr_seq_chk (
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    input wire logic                     i_resin_n,
    input wire logic                     i_nmi,
    input wire logic                     i_power_down_request_bit,
    input wire logic                     i_halt_exec,
    input wire logic                     i_pdtmr_in,
    input wire logic                     o_pdtmr_out,
    input wire logic                     o_pdtmr_oe,
    input wire logic                     o_clk_en,
    input wire logic                     o_resout,
    input wire logic                     o_bus_abort,
    input wire pwr_seq_pkg::pwr_status_t o_status
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // entry needs both the bit and the halt; a wake needs the latched interrupt while down
    sequence s_req; $past(i_power_down_request_bit && i_halt_exec); endsequence
    sequence s_nmi_down; $rose(i_nmi) ##0 o_status.powered_down; endsequence
    AST_ENTRY: assert property ($fell(o_clk_en) |-> s_req) else $error("clocks stopped without request");
    AST_EXIT: assert property ($fell(o_status.powered_down) |-> $past(o_status.nmi_pending) || o_resout)
        else $error("left power-down on a wrong event");
    AST_NMI_WAKE: assert property ($rose(o_clk_en) && !o_resout |-> $past(i_pdtmr_in, 3) && !o_pdtmr_oe)
        else $error("clocks back before pin threshold");
    AST_RST_WAKE: assert property ($rose(o_resout) |-> o_clk_en) else $error("reset wake delayed");
    AST_LATCH: assert property (s_nmi_down |-> ##[1:4] o_status.nmi_pending) else $error("interrupt lost");
    AST_RESOUT: assert property (!i_resin_n [*4] |-> o_resout) else $error("reset out low");
    AST_ABORT: assert property (o_bus_abort == o_resout) else $error("bus abort differs");
    AST_DISCH: assert property (o_status.powered_down && !o_status.nmi_pending |-> o_pdtmr_oe && !o_pdtmr_out)
        else $error("pin not discharged");
endmodule
bind powerdown_entry_exit_control pwr_seq_chk u_chk (.i_clk, .i_rst, .i_resin_n, .i_nmi, .i_power_down_request_bit,
    .i_halt_exec, .i_pdtmr_in, .o_pdtmr_out, .o_pdtmr_oe, .o_clk_en, .o_resout, .o_bus_abort, .o_status);

// *** tb/pdtmr_cap.sv ***
// timing capacitor model on the wake delay pin
`timescale 1ns/1ns
module pdtmr_cap #(
    parameter int CHG = 6
) (
    input  wire logic i_clk,
    input  wire logic i_oe,
    input  wire logic i_out,
    output logic      o_level
);
    int cnt_q;
    // charge count restarts while the pin is pulled low
    always_ff @(posedge i_clk) begin
        if (i_oe && !i_out) cnt_q <= 0;
        else if (cnt_q < CHG) cnt_q <= cnt_q + 1;
    end
    // crossing comes CHG cycles after release, sized to cover oscillator start-up
    assign o_level = i_oe ? i_out : (cnt_q >= CHG);
endmodule

// *** tb/powerdown_entry_exit_control_tb.sv ***
// self-checking bench for the power-down sequencer
`timescale 1ns/1ns
module powerdown_entry_exit_control_tb;
    import pwr_seq_pkg::*;
    localparam int DCYC = 4;
    localparam int CHG = 6;
    logic clk = 0, rst = 1, resin_n = 1, nmi = 0, req_bit = 0, halt = 0, taken = 0;
    logic pin, pd_out, oe, clk_en, resout, abort;
    pwr_status_t status;
    int n_mismatch = 0, tests_run = 0, n;
    powerdown_entry_exit_control #(.DISCHARGE_CYC(DCYC)) DUT (.i_clk(clk), .i_rst(rst), .i_resin_n(resin_n),
        .i_nmi(nmi), .i_power_down_request_bit(req_bit), .i_halt_exec(halt), .i_nmi_taken(taken),
        .i_pdtmr_in(pin), .o_pdtmr_out(pd_out), .o_pdtmr_oe(oe), .o_clk_en(clk_en), .o_resout(resout),
        .o_bus_abort(abort), .o_status(status));
    pdtmr_cap #(.CHG(CHG)) u_cap (.i_clk(clk), .i_oe(oe), .i_out(pd_out), .o_level(pin));
    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // inputs move 1 ns after the edge so the sampling edge never races them
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 200) begin
            cyc(1);
            n++;
        end
        if (n >= 200) begin
            n_mismatch++;
            $display("Error at %0t: wait timed out, got %h expected %h", $time, s, v);
        end
    endtask
    task automatic t_enter;
        halt = 1;
        cyc(1);
        halt = 0;
        cyc(1);
        chk(clk_en, 1'b0);
        chk(status.clk_en, 1'b0);
        chk(oe, 1'b1);
        chk(pd_out, 1'b0);
    endtask
    task automatic t_reset;
        chk(resout, 1'b1);
        rst = 0;
        wait_for(resout, 1'b0);
        chk(abort, 1'b0);
    endtask
    task automatic t_refuse;
        halt = 1; // halt alone, then bit alone
        cyc(1);
        halt = 0;
        req_bit = 1;
        cyc(5);
        chk(clk_en, 1'b1);
        chk(status.powered_down, 1'b0);
    endtask
    task automatic t_nmi_wake;
        t_enter();
        taken = 1;
        cyc(1);
        taken = 0;
        cyc(30);
        chk(status.powered_down, 1'b1);
        nmi = 1; // one-cycle pulse must be remembered
        cyc(1);
        nmi = 0;
        wait_for(clk_en, 1'b1);
        chk(n >= CHG + 3 && n <= CHG + DCYC + 10, 1'b1);
        chk(status.clk_en, 1'b1);
        chk(oe, 1'b0);
        chk(status.nmi_pending, 1'b1);
        taken = 1;
        cyc(1);
        taken = 0;
    endtask
    task automatic t_reset_wake;
        t_enter();
        resin_n = 0;
        wait_for(resout, 1'b1);
        chk(clk_en, 1'b1);
        chk(abort, 1'b1);
        chk(oe, 1'b0);
        cyc(10);
        chk(resout, 1'b1);
        resin_n = 1;
        wait_for(resout, 1'b0);
        chk(status.powered_down, 1'b0);
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
    initial begin
        cyc(8);
        t_reset();
        t_refuse();
        t_nmi_wake();
        t_reset_wake();
        final_report();
    end
endmodule
